// file: design/mssp_serial_slave.sv
`timescale 1ns/1ps
module mssp_serial_slave #(
	parameter int unsigned TIMEOUT_CYCLES = mssp_pkg::TIMEOUT_CYCLES
) (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        scl_in,
	output wire logic        scl_out,
	output wire logic        scl_oe,
	input  wire logic        sda_in,
	output wire logic        sda_out,
	output wire logic        sda_oe,
	input  wire logic        addr_strap_low,
	input  wire logic        addr_strap_high,
	input  wire logic        alert_pending,
	input  wire logic [15:0] rd_data,
	output logic      [7:0]  reg_ptr,
	output logic      [15:0] wr_data,
	output logic             wr_en,
	output logic             rd_load,
	output logic             alert_ack,
	output logic             hs_mode,
	output wire logic        busy
);

	// Decode one strap from its level at start, on high data bits, first fall
	function automatic logic [1:0] strap_code(input logic at_start, input logic at_rise, input logic at_fall);
		logic [1:0] code;
		code = mssp_pkg::STRAP_GND;
		if (at_start) begin
			code = at_fall ? mssp_pkg::STRAP_VS : mssp_pkg::STRAP_SCL;
		end else begin
			code = at_rise ? mssp_pkg::STRAP_SDA : mssp_pkg::STRAP_GND;
		end
		return code;
	endfunction : strap_code

	mssp_pkg::mssp_state_e state;
	logic [3:0]  cnt;
	logic [7:0]  rx_sh;
	logic [7:0]  tx_sh;
	logic        sda_drive;
	logic        is_read;
	logic        is_alert;
	logic        master_ack;
	logic [1:0]  byte_idx;
	logic [7:0]  hi_byte;
	logic [15:0] rd_word;
	logic        hs_pend;
	logic [1:0]  strap_s0;
	logic [1:0]  strap_s1;
	logic [1:0]  strap_s2;
	logic [31:0] to_cnt;
	logic [3:0]  raw_in;
	wire  [3:0]  filt;
	logic        scl_d;
	logic        sda_d;

	// Two-flop sync and spike filter per pin: scl, sda, straps
	assign raw_in = {addr_strap_high, addr_strap_low, sda_in, scl_in};
	wire [mssp_pkg::FILT_W-1:0] filt_len = hs_mode ? mssp_pkg::FILT_W'(mssp_pkg::HS_SPIKE_CYCLES) :
	                                                 mssp_pkg::FILT_W'(mssp_pkg::FS_SPIKE_CYCLES);
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_filt
			logic                       meta;
			logic                       sync;
			logic                       lvl;
			logic [mssp_pkg::FILT_W-1:0] run;
			// Level must differ for filt_len cycles before it is taken
			always_ff @(posedge ref_clk) begin
				if (rst) begin
					meta      <= 1'b1;
					sync      <= 1'b1;
					run       <= '0;
					lvl       <= 1'b1;
				end else begin
					meta <= raw_in[gi];
					sync <= meta;
					if (sync == lvl) begin
						run <= '0;
					end else if (run >= filt_len - 1'b1) begin
						run <= '0;
						lvl <= sync;
					end else begin
						run <= run + 1'b1;
					end
				end
			end
			// One driver per filtered bit
			assign filt[gi] = lvl;
		end
	endgenerate

	// Edge and condition decode on filtered lines
	wire scl_f      = filt[0];
	wire sda_f      = filt[1];
	wire [1:0] strap_f = filt[3:2];
	wire scl_rise   = scl_f & ~scl_d;
	wire scl_fall   = ~scl_f & scl_d;
	wire start_cond = scl_f & scl_d & sda_d & ~sda_f;
	wire stop_cond  = scl_f & scl_d & ~sda_d & sda_f;
	wire to_expire  = (to_cnt >= TIMEOUT_CYCLES - 1);

	// Own address from upper bits and both straps
	wire [6:0] own_addr = {mssp_pkg::ADDR_UPPER,
	                       strap_code(strap_s0[1], strap_s1[1], strap_s2[1]),
	                       strap_code(strap_s0[0], strap_s1[0], strap_s2[0])};
	wire addr_hit  = (rx_sh[7:1] == own_addr);
	wire alert_hit = (rx_sh[7:1] == mssp_pkg::ALERT_RESP_ADR) & rx_sh[0] & alert_pending;
	wire hs_code   = (rx_sh[7:3] == mssp_pkg::HS_CODE_TOP);
	wire byte_done = (cnt == mssp_pkg::BITS_PER_BYTE);

	// Open-drain pins: clock never driven, data only pulled low
	assign scl_out = 1'b0;
	assign scl_oe  = 1'b0;
	assign sda_out = 1'b0;
	assign sda_oe  = sda_drive;
	assign busy    = (state != mssp_pkg::ST_IDLE);

	// Previous filtered levels
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_d <= scl_f;
			sda_d <= sda_f;
		end
	end

	// Timeout counts while clock held low in a transaction
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			to_cnt <= '0;
		end else if (state == mssp_pkg::ST_IDLE || scl_f || start_cond) begin
			to_cnt <= '0;
		end else if (!to_expire) begin
			to_cnt <= to_cnt + 1;
		end
	end

	// Byte engine
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state      <= mssp_pkg::ST_IDLE;
			cnt        <= '0;
			rx_sh      <= '0;
			tx_sh      <= '0;
			sda_drive  <= 1'b0;
			is_read    <= 1'b0;
			is_alert   <= 1'b0;
			master_ack <= 1'b0;
			byte_idx   <= mssp_pkg::WB_PTR;
			hi_byte    <= '0;
			rd_word    <= '0;
			hs_pend    <= 1'b0;
			hs_mode    <= 1'b0;
			strap_s0   <= '0;
			strap_s1   <= '0;
			strap_s2   <= '0;
			reg_ptr    <= '0;
			wr_data    <= '0;
			wr_en      <= 1'b0;
			rd_load    <= 1'b0;
			alert_ack  <= 1'b0;
		end else begin
			wr_en     <= 1'b0;
			rd_load   <= 1'b0;
			alert_ack <= 1'b0;
			if (stop_cond) begin
				state     <= mssp_pkg::ST_IDLE;
				sda_drive <= 1'b0;
				hs_mode   <= 1'b0;
				hs_pend   <= 1'b0;
			end else if (start_cond) begin
				state     <= mssp_pkg::ST_ADDR;
				cnt       <= '0;
				sda_drive <= 1'b0;
				strap_s0  <= strap_f;
				strap_s1  <= '0;
				if (hs_pend) begin
					hs_mode <= 1'b1;
					hs_pend <= 1'b0;
				end
			end else if (to_expire && state != mssp_pkg::ST_IDLE) begin
				state     <= mssp_pkg::ST_IDLE;
				sda_drive <= 1'b0;
			end else begin
				unique case (state)
					mssp_pkg::ST_IDLE: begin
					end
					mssp_pkg::ST_ADDR: begin
						if (scl_rise) begin
							rx_sh <= {rx_sh[6:0], sda_f};
							cnt   <= cnt + 1'b1;
							strap_s1 <= strap_s1 | (strap_f & {2{sda_f}}); // data-tied strap seen on any high bit
						end else if (scl_fall && cnt == '0) begin
							strap_s2 <= strap_f;
						end else if (scl_fall && byte_done) begin
							cnt <= '0;
							if (addr_hit) begin
								state     <= mssp_pkg::ST_ADDR_ACK;
								sda_drive <= 1'b1;
								is_read   <= rx_sh[0];
								is_alert  <= 1'b0;
								byte_idx  <= mssp_pkg::WB_PTR;
								rd_word   <= rd_data;
								rd_load   <= rx_sh[0];
							end else if (alert_hit) begin
								state     <= mssp_pkg::ST_ADDR_ACK;
								sda_drive <= 1'b1;
								is_read   <= 1'b1;
								is_alert  <= 1'b1;
							end else begin
								hs_pend <= hs_code | hs_pend;
								state   <= mssp_pkg::ST_IGNORE;
							end
						end
					end
					mssp_pkg::ST_ADDR_ACK: begin
						if (scl_fall) begin
							cnt <= '0;
							if (is_alert) begin
								tx_sh     <= {own_addr, 1'b0};
								sda_drive <= ~own_addr[6];
								state     <= mssp_pkg::ST_TX;
							end else if (is_read) begin
								tx_sh     <= rd_word[15:8];
								sda_drive <= ~rd_word[15];
								state     <= mssp_pkg::ST_TX;
							end else begin
								sda_drive <= 1'b0;
								state     <= mssp_pkg::ST_RX;
							end
						end
					end
					mssp_pkg::ST_RX: begin
						if (scl_rise) begin
							rx_sh <= {rx_sh[6:0], sda_f};
							cnt   <= cnt + 1'b1;
						end else if (scl_fall && byte_done) begin
							cnt       <= '0;
							state     <= mssp_pkg::ST_RX_ACK;
							sda_drive <= 1'b1;
							unique case (byte_idx)
								mssp_pkg::WB_PTR: begin
									reg_ptr  <= rx_sh;
									byte_idx <= mssp_pkg::WB_HIGH;
								end
								mssp_pkg::WB_HIGH: begin
									hi_byte  <= rx_sh;
									byte_idx <= mssp_pkg::WB_LOW;
								end
								mssp_pkg::WB_LOW: begin
									wr_data  <= {hi_byte, rx_sh};
									wr_en    <= 1'b1;
									byte_idx <= mssp_pkg::WB_DONE;
								end
								mssp_pkg::WB_DONE: begin
								end
							endcase
						end
					end
					mssp_pkg::ST_RX_ACK: begin
						if (scl_fall) begin
							sda_drive <= 1'b0;
							state     <= mssp_pkg::ST_RX;
						end
					end
					mssp_pkg::ST_TX: begin
						if (scl_rise && tx_sh[7] && !sda_f && is_alert) begin
							sda_drive <= 1'b0;
							state     <= mssp_pkg::ST_IGNORE;
						end else if (scl_fall && cnt == mssp_pkg::LAST_TX_BIT) begin
							cnt       <= '0;
							sda_drive <= 1'b0;
							state     <= mssp_pkg::ST_TX_ACK;
							alert_ack <= is_alert;
						end else if (scl_fall) begin
							tx_sh     <= {tx_sh[6:0], 1'b0};
							sda_drive <= ~tx_sh[6];
							cnt       <= cnt + 1'b1;
						end
					end
					mssp_pkg::ST_TX_ACK: begin
						if (scl_rise) begin
							master_ack <= ~sda_f;
						end else if (scl_fall) begin
							if (master_ack && !is_alert) begin
								state <= mssp_pkg::ST_TX;
								if (byte_idx == mssp_pkg::WB_PTR) begin
									tx_sh     <= rd_word[7:0];
									sda_drive <= ~rd_word[7];
									byte_idx  <= mssp_pkg::WB_HIGH;
								end else begin
									tx_sh     <= rd_data[15:8];
									sda_drive <= ~rd_data[15];
									rd_word   <= rd_data;
									rd_load   <= 1'b1;
									byte_idx  <= mssp_pkg::WB_PTR;
								end
							end else begin
								state <= mssp_pkg::ST_IGNORE;
							end
						end
					end
					mssp_pkg::ST_IGNORE: begin
					end
				endcase
			end
		end
	end

endmodule : mssp_serial_slave

// file: design/mssp_pkg.sv
package mssp_pkg;

	// Clock rate of ref_clk
	localparam int unsigned CLK_PERIOD_NS = 5;
	localparam int unsigned CLK_KHZ       = 200000;

	// Bus timeout
	localparam int unsigned TIMEOUT_MS     = 28;
	localparam int unsigned TIMEOUT_CYCLES = TIMEOUT_MS * CLK_KHZ;

	// Spike suppression widths, least times rounded up
	localparam int unsigned FS_SPIKE_NS     = 50;
	localparam int unsigned HS_SPIKE_NS     = 10;
	localparam int unsigned FS_SPIKE_CYCLES = (FS_SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned HS_SPIKE_CYCLES = (HS_SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned FILT_W          = 4;

	// Bus rates supported
	localparam int unsigned FS_MIN_KHZ = 1;
	localparam int unsigned FS_MAX_KHZ = 400;
	localparam int unsigned HS_MAX_KHZ = 3400;

	// Address layout
	localparam logic [2:0] ADDR_UPPER     = 3'h4;
	localparam logic [6:0] ALERT_RESP_ADR = 7'h0C;
	localparam logic [4:0] HS_CODE_TOP    = 5'h01;

	// Strap level encodings
	localparam logic [1:0] STRAP_GND = 2'h0;
	localparam logic [1:0] STRAP_VS  = 2'h1;
	localparam logic [1:0] STRAP_SDA = 2'h2;
	localparam logic [1:0] STRAP_SCL = 2'h3;

	// Byte positions inside a write
	localparam logic [1:0] WB_PTR  = 2'h0;
	localparam logic [1:0] WB_HIGH = 2'h1;
	localparam logic [1:0] WB_LOW  = 2'h2;
	localparam logic [1:0] WB_DONE = 2'h3;

	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] LAST_TX_BIT   = 4'h7;

	typedef enum logic [2:0] {
		ST_IDLE     = 3'b000,
		ST_ADDR     = 3'b001,
		ST_ADDR_ACK = 3'b010,
		ST_RX       = 3'b011,
		ST_RX_ACK   = 3'b100,
		ST_TX       = 3'b101,
		ST_TX_ACK   = 3'b110,
		ST_IGNORE   = 3'b111
	} mssp_state_e;

endpackage : mssp_pkg

// file: verif/mssp_bus_master.sv
`timescale 1ns/1ps
module mssp_bus_master (
	input  wire logic ref_clk,
	input  wire logic sda_wire,
	output logic      scl,
	output logic      sda_drv
);
	localparam int H = 20; // Half bit, longer than the spike filter

	// Both lines released while the bus is idle
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end

	// Drive both lines just after an edge, then hold
	task automatic step(input logic c, input logic d, input int n);
		@(posedge ref_clk);
		scl <= c;
		sda_drv <= d;
		repeat (n) @(posedge ref_clk);
	endtask : step

	// Start: data falls while the clock is held high
	task automatic start();
		step(1'b0, sda_drv, H / 2);
		step(1'b0, 1'b1, H / 2);
		step(1'b1, 1'b1, H);
		step(1'b1, 1'b0, H);
	endtask : start

	task automatic stop();
		step(1'b0, sda_drv, H / 2);
		step(1'b0, 1'b0, H / 2);
		step(1'b1, 1'b0, H);
		step(1'b1, 1'b1, H);
	endtask : stop

	// One bit; data stable through clock high
	task automatic bit_io(input logic b, output logic s);
		step(1'b0, sda_drv, H / 2);
		step(1'b0, b, H / 2);
		step(1'b1, b, H);
		s = sda_wire;
	endtask : bit_io

	// Eight bits then the acknowledge slot
	task automatic xbyte(input logic [7:0] d, input logic last, output logic [7:0] r, output logic ack);
		for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
		bit_io(last, ack);
	endtask : xbyte

	// Clock held low to stall the transfer
	task automatic stall(input int n);
		step(1'b0, sda_drv, n);
	endtask : stall
endmodule : mssp_bus_master

// file: verif/mssp_slave_properties.sv
`timescale 1ns/1ps
module mssp_slave_props #(
	parameter int unsigned TIMEOUT_CYCLES = 2000
) (
	input wire logic       ref_clk,
	input wire logic       rst,
	input wire logic       scl_in,
	input wire logic       sda_in,
	input wire logic       scl_oe,
	input wire logic       sda_out,
	input wire logic       sda_oe,
	input wire logic [7:0] reg_ptr,
	input wire logic       wr_en,
	input wire logic       rd_load,
	input wire logic       alert_ack,
	input wire logic       hs_mode,
	input wire logic       busy
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	logic [31:0] low_cnt;

	// Clock-low cycles inside a transaction
	always_ff @(posedge ref_clk) begin
		if (rst || !busy || scl_in)
			low_cnt <= 32'h0;
		else
			low_cnt <= low_cnt + 32'h1;
	end

	sequence start_seen;
		$fell(sda_in) && scl_in && $past(scl_in);
	endsequence
	sequence stop_seen;
		$rose(sda_in) && scl_in && $past(scl_in);
	endsequence

	AST_NO_CLOCK_DRIVE: assert property (scl_oe == 1'b0 && sda_out == 1'b0)
		else $error("device drives clock or data high");
	AST_START_BUSY: assert property (start_seen |-> ##[1:20] busy)
		else $error("start not taken");
	AST_STOP_IDLE: assert property (stop_seen |-> ##[1:20] !busy)
		else $error("stop not taken");
	AST_HS_DROP: assert property (stop_seen |-> ##[1:20] !hs_mode)
		else $error("high speed kept after stop");
	AST_TIMEOUT_BOUND: assert property (low_cnt <= TIMEOUT_CYCLES + 32)
		else $error("stalled transfer not abandoned");
	AST_IDLE_RELEASED: assert property (!busy |-> !sda_oe)
		else $error("data held while idle");
	AST_WR_ONE_CYCLE: assert property (wr_en |=> !wr_en)
		else $error("write pulse too long");
	AST_WR_WITH_ACK: assert property (wr_en |-> sda_oe && busy)
		else $error("write without acknowledge");
	AST_RDLOAD_ONE: assert property (rd_load |=> !rd_load)
		else $error("read load pulse too long");
	AST_PTR_HELD: assert property (!busy |=> $stable(reg_ptr))
		else $error("pointer moved while idle");

	// Main scenarios reached
	COV_WRITE: cover property (wr_en);
	COV_READ: cover property (rd_load);
	COV_ALERT: cover property (alert_ack);
	COV_HS: cover property ($rose(hs_mode));
endmodule : mssp_slave_props

bind mssp_serial_slave mssp_slave_props #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) i_mssp_slave_props (
	.ref_clk(ref_clk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in), .scl_oe(scl_oe),
	.sda_out(sda_out), .sda_oe(sda_oe), .reg_ptr(reg_ptr), .wr_en(wr_en), .rd_load(rd_load),
	.alert_ack(alert_ack), .hs_mode(hs_mode), .busy(busy));

// file: verif/testbench.sv
`timescale 1ns/1ps
module testbench;
	logic        ref_clk = 1'b0;
	logic        rst = 1'b1;
	logic        alert_pending = 1'b0;
	logic        scl, sda_drv, sda_oe, wr_en, rd_load, alert_ack, hs_mode, busy, a;
	logic [1:0]  cl = 2'h0, ch = 2'h0;
	logic [6:0]  own;
	logic [7:0]  reg_ptr, p, r;
	logic [15:0] wr_data, v, w;
	logic [15:0] mem [256];
	int          fails = 0, n_compared = 0, cyc = 0, n_wr = 0, n_al = 0, n;
	wire         sda = sda_drv & ~sda_oe;
	wire         strap_l = cl[1] ? (cl[0] ? scl : sda) : cl[0];
	wire         strap_h = ch[1] ? (ch[0] ? scl : sda) : ch[0];
	wire [15:0]  rd_data = mem[reg_ptr];

	always #2.5 ref_clk = ~ref_clk;

	// Register file, pulse counts and hang guard
	always @(posedge ref_clk) begin
		if (wr_en) mem[reg_ptr] <= wr_data;
		n_wr <= n_wr + wr_en;
		n_al <= n_al + alert_ack;
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			fails = fails + 1;
			wrap_up();
		end
	end

	mssp_serial_slave #(.TIMEOUT_CYCLES(2000)) i_mssp_serial_slave (
		.ref_clk(ref_clk), .rst(rst), .scl_in(scl), .scl_out(), .scl_oe(), .sda_in(sda),
		.sda_out(), .sda_oe(sda_oe), .addr_strap_low(strap_l), .addr_strap_high(strap_h),
		.alert_pending(alert_pending), .rd_data(rd_data), .reg_ptr(reg_ptr), .wr_data(wr_data),
		.wr_en(wr_en), .rd_load(rd_load), .alert_ack(alert_ack), .hs_mode(hs_mode), .busy(busy));

	mssp_bus_master i_mssp_bus_master (.ref_clk(ref_clk), .sda_wire(sda), .scl(scl), .sda_drv(sda_drv));

	// Expected own address: fixed upper bits, high strap, low strap
	function automatic logic [6:0] exp_addr(input logic [1:0] hi, input logic [1:0] lo);
		return {mssp_pkg::ADDR_UPPER, hi, lo};
	endfunction : exp_addr

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
		n_compared++;
		if (s !== e) begin
			fails++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : wrap_up

	// Byte sent by the master, acknowledge compared
	task automatic tx(input logic [7:0] d, input logic exp_ack, input string nm);
		i_mssp_bus_master.xbyte(d, 1'b1, r, a);
		chk(nm, exp_ack, a);
	endtask : tx

	task automatic wr_word(input logic [7:0] ptr, input logic [15:0] val, input int nb);
		i_mssp_bus_master.start();
		tx({own, 1'b0}, 1'b0, "addr ack");
		tx(ptr, 1'b0, "ptr ack");
		if (nb > 1) tx(val[15:8], 1'b0, "high ack");
		if (nb > 2) tx(val[7:0], 1'b0, "low ack");
		i_mssp_bus_master.stop();
	endtask : wr_word

	task automatic rd_word(output logic [15:0] val);
		i_mssp_bus_master.start();
		tx({own, 1'b1}, 1'b0, "read addr ack");
		i_mssp_bus_master.xbyte(8'hFF, 1'b0, val[15:8], a);
		i_mssp_bus_master.xbyte(8'hFF, 1'b1, val[7:0], a);
		i_mssp_bus_master.stop();
	endtask : rd_word

	initial begin
		p = 8'($urandom(22409));
		repeat (8) @(posedge ref_clk);
		rst <= 1'b0;
		// Every strap level on both pins, then random ones
		for (int i = 0; i < 6; i++) begin
			@(posedge ref_clk);
			cl <= (i < 4) ? i[1:0] : 2'($urandom);
			ch <= (i < 4) ? 2'(3 - i) : 2'($urandom);
			p = 8'($urandom);
			v = 16'($urandom);
			repeat (20) @(posedge ref_clk);
			own = exp_addr(ch, cl);
			wr_word(p, v, 3);
			rd_word(w);
			chk("word", v, w);
			chk("ptr", p, reg_ptr);
		end
		$display("straps test done");
		// Neighbour written, then write cut after high byte
		wr_word(p ^ 8'h01, ~v, 3);
		n = n_wr;
		wr_word(p, 16'h0000, 2);
		chk("odd byte", n, n_wr);
		repeat (2) begin
			rd_word(w);
			chk("retained", v, w);
		end
		$display("pointer test done");
		// Foreign address ignored
		i_mssp_bus_master.start();
		tx({own ^ 7'h01, 1'b0}, 1'b1, "foreign nack");
		tx(8'h00, 1'b1, "ignored byte");
		i_mssp_bus_master.stop();
		$display("foreign test done");
		// Alert response
		alert_pending <= 1'b1;
		i_mssp_bus_master.start();
		tx({7'h0C, 1'b1}, 1'b0, "alert ack");
		i_mssp_bus_master.xbyte(8'hFF, 1'b1, r, a);
		i_mssp_bus_master.stop();
		alert_pending <= 1'b0;
		chk("alert addr", {own, 1'b0}, r);
		chk("alert pulse", 1, n_al);
		$display("alert test done");
		// High-speed code, restart, stop
		i_mssp_bus_master.start();
		tx(8'h0B, 1'b1, "hs code nack");
		i_mssp_bus_master.start();
		chk("hs on", 1, hs_mode);
		i_mssp_bus_master.stop();
		chk("hs off", 0, hs_mode);
		$display("hs test done");
		// Stalled read abandoned while the device pulls data low
		wr_word(p, 16'h7FFF, 3);
		i_mssp_bus_master.start();
		tx({own, 1'b1}, 1'b0, "stall addr ack");
		i_mssp_bus_master.stall(100);
		chk("stall drive", 1, sda_oe);
		chk("stall busy", 1, busy);
		i_mssp_bus_master.stall(2000);
		chk("timeout busy", 0, busy);
		chk("timeout sda", 0, sda_oe);
		i_mssp_bus_master.stop();
		$display("timeout test done");
		wrap_up();
	end
endmodule : testbench
